// ===== src/bsl_regs.sv
// Purpose: secondary tenure timer and I/O window registers of a bridge
// Assumes: upper-half I/O bits arrive as inputs from their own registers
// Notes: one clock mclk, asynchronous active-low reset
`default_nettype none
module bsl_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be_b,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // upper-half I/O window bits
  input wire logic [15:0] io_bottom_upper,
  input wire logic [15:0] io_top_upper,
  // secondary mastering
  input wire logic sec_frame_start,
  input wire logic sec_master_busy,
  input wire logic sec_gnt_lost,
  input wire logic sec_mwi,
  output logic tenure_expired,
  output logic end_after_first_data,
  // I/O forwarding decision
  input wire logic io_req,
  input wire logic [31:0] io_addr,
  output logic io_forward
);
  ////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] tenure_r, tenure_nxt;
  logic [3:0] iob_r, iob_nxt, iot_r, iot_nxt;
  logic [31:0] rdata_nxt;

  always_comb begin
    tenure_nxt = tenure_r;
    iob_nxt = iob_r;
    iot_nxt = iot_r;
    rdata_nxt = 32'h0000_0000;
    if (cfg_wr && cfg_addr == bsl_pkg::OFS_TENURE && !cfg_be_b[3]) begin
      tenure_nxt = cfg_wdata[bsl_pkg::TENURE_LSB +: bsl_pkg::TENURE_W];
    end
    if (cfg_wr && cfg_addr == bsl_pkg::OFS_IOWIN && !cfg_be_b[0]) begin
      iob_nxt = cfg_wdata[bsl_pkg::IOB_LSB +: bsl_pkg::WIN_W];
    end
    if (cfg_wr && cfg_addr == bsl_pkg::OFS_IOWIN && !cfg_be_b[1]) begin
      iot_nxt = cfg_wdata[bsl_pkg::IOT_LSB +: bsl_pkg::WIN_W];
    end
    if (cfg_rd && cfg_addr == bsl_pkg::OFS_TENURE) begin
      rdata_nxt = {tenure_r, bsl_pkg::TENURE_STEP, 24'h00_0000};
    end else if (cfg_rd && cfg_addr == bsl_pkg::OFS_IOWIN) begin
      rdata_nxt = {16'h0000, iot_r, bsl_pkg::DECODE32, iob_r, bsl_pkg::DECODE32};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tenure_r <= bsl_pkg::TENURE_RST;
      iob_r <= bsl_pkg::IOB_RST;
      iot_r <= bsl_pkg::IOT_RST;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      tenure_r <= tenure_nxt;
      iob_r <= iob_nxt;
      iot_r <= iot_nxt;
      cfg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // tenure timer
  logic [7:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt, exp_nxt, efd_nxt;
  logic [7:0] limit;

  always_comb begin
    limit = {tenure_r, bsl_pkg::TENURE_STEP};
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = tenure_expired;
    if (sec_frame_start) begin
      cnt_nxt = 8'h01;
      run_nxt = 1'b1;
      exp_nxt = limit != 8'h00 && limit <= 8'h01;
    end else if (!sec_master_busy) begin
      run_nxt = 1'b0;
      exp_nxt = 1'b0;
    end else if (run_r && !tenure_expired) begin
      cnt_nxt = cnt_r + 8'h01;
      exp_nxt = limit != 8'h00 && cnt_nxt >= limit;
    end
    efd_nxt = sec_master_busy && sec_gnt_lost && !sec_mwi && tenure_r == 5'h00;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
      tenure_expired <= 1'b0;
      end_after_first_data <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      tenure_expired <= exp_nxt;
      end_after_first_data <= efd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // I/O window decode
  logic [19:0] a_hi, bot, top;
  logic fwd_nxt;

  always_comb begin
    a_hi = io_addr[31:12];
    bot = {io_bottom_upper, iob_r};
    top = {io_top_upper, iot_r};
    fwd_nxt = io_req && a_hi >= bot && a_hi <= top;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      io_forward <= 1'b0;
    end else begin
      io_forward <= fwd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  // independent tenure cycle count for the expiry check
  logic [8:0] chk_cnt_r, chk_cnt_nxt;

  always_comb begin
    chk_cnt_nxt = chk_cnt_r;
    if (sec_frame_start) begin
      chk_cnt_nxt = 9'h001;
    end else if (!sec_master_busy) begin
      chk_cnt_nxt = 9'h000;
    end else if (chk_cnt_r != 9'h1FF) begin
      chk_cnt_nxt = chk_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      chk_cnt_r <= 9'h000;
    end else begin
      chk_cnt_r <= chk_cnt_nxt;
    end
  end

  a_fwd_window: assert property (@(posedge mclk) disable iff (!rst_b)
    io_req |=> io_forward == ($past(io_addr[31:12]) >= {$past(io_bottom_upper), $past(iob_r)}
      && $past(io_addr[31:12]) <= {$past(io_top_upper), $past(iot_r)}))
    else $error("io forward decision wrong");
  a_fwd_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !io_req |=> !io_forward) else $error("forward without request");
  a_low_bits_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(cfg_rd) && $past(cfg_addr) == bsl_pkg::OFS_TENURE |-> cfg_rdata[26:0] == 27'h0)
    else $error("timer low bits not zero");
  a_decode_nibble: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(cfg_rd) && $past(cfg_addr) == bsl_pkg::OFS_IOWIN |-> cfg_rdata[3:0] == 4'h1 && cfg_rdata[11:8] == 4'h1)
    else $error("decode width nibble wrong");
  a_bottom_write: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_addr == bsl_pkg::OFS_IOWIN && !cfg_be_b[0] |=> iob_r == $past(cfg_wdata[7:4]))
    else $error("bottom write lost");
  a_top_write: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_addr == bsl_pkg::OFS_IOWIN && !cfg_be_b[1] |=> iot_r == $past(cfg_wdata[15:12]))
    else $error("top write lost");
  a_timer_expire: assert property (@(posedge mclk) disable iff (!rst_b)
    sec_frame_start && tenure_r == 5'h01 && !cfg_wr ##1 (sec_master_busy && !sec_frame_start) [*7]
      |=> tenure_expired) else $error("timer did not expire at eight");
  a_zero_ends: assert property (@(posedge mclk) disable iff (!rst_b)
    sec_master_busy && sec_gnt_lost && sec_mwi |=> !end_after_first_data)
    else $error("zero setting ended a write and invalidate");
  a_expire_at_count: assert property (@(posedge mclk) disable iff (!rst_b)
    chk_cnt_r != 9'h000 && limit != 8'h00 |-> tenure_expired == (chk_cnt_r >= {1'b0, limit}))
    else $error("tenure expiry not at programmed count");
  a_expire_clears: assert property (@(posedge mclk) disable iff (!rst_b)
    !sec_master_busy && !sec_frame_start |=> !tenure_expired)
    else $error("expiry held after tenure ended");
  a_frame_restart: assert property (@(posedge mclk) disable iff (!rst_b)
    sec_frame_start |=> cnt_r == 8'h01)
    else $error("frame did not restart the count");
  a_tenure_write: assert property (@(posedge mclk) disable iff (!rst_b)
    cfg_wr && cfg_addr == bsl_pkg::OFS_TENURE && !cfg_be_b[3] |=> tenure_r == $past(cfg_wdata[31:27]))
    else $error("tenure write lost");
  a_tenure_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    !(cfg_wr && cfg_addr == bsl_pkg::OFS_TENURE && !cfg_be_b[3]) |=> $stable(tenure_r))
    else $error("tenure changed without write");
  a_zero_no_expire: assert property (@(posedge mclk) disable iff (!rst_b)
    tenure_r == 5'h00 && !tenure_expired |=> !tenure_expired)
    else $error("zero setting expired");
  a_zero_first_data: assert property (@(posedge mclk) disable iff (!rst_b)
    sec_master_busy && sec_gnt_lost && !sec_mwi && tenure_r == 5'h00 |=> end_after_first_data)
    else $error("zero setting did not end after first data");
  a_efd_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    !sec_master_busy |=> !end_after_first_data)
    else $error("first data end without tenure");
  a_window_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    !(cfg_wr && cfg_addr == bsl_pkg::OFS_IOWIN) |=> $stable(iob_r) && $stable(iot_r))
    else $error("window changed without write");
  a_upper_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(cfg_rd) && $past(cfg_addr) == bsl_pkg::OFS_IOWIN |-> cfg_rdata[31:16] == 16'h0000)
    else $error("window upper half not zero");
  a_fwd_bottom: assert property (@(posedge mclk) disable iff (!rst_b)
    io_req && {io_bottom_upper, iob_r} <= {io_top_upper, iot_r}
      && io_addr[31:12] == {io_bottom_upper, iob_r} |=> io_forward)
    else $error("bottom bound not inclusive");
  a_fwd_top: assert property (@(posedge mclk) disable iff (!rst_b)
    io_req && {io_bottom_upper, iob_r} <= {io_top_upper, iot_r}
      && io_addr[31:12] == {io_top_upper, iot_r} |=> io_forward)
    else $error("top bound not inclusive");
endmodule
`default_nettype wire

// ===== shared/bsl_pkg.sv
// Purpose: constants for the bridge tenure timer and I/O window registers
// Assumes: dword configuration accesses with active-low byte enables
// Notes: offsets are byte addresses of configuration dwords
`default_nettype none
package bsl_pkg;
  localparam logic [7:0] OFS_TENURE = 8'h18;
  localparam logic [7:0] OFS_IOWIN = 8'h1C;
  localparam int TENURE_LSB = 27;
  localparam int TENURE_W = 5;
  localparam int IOB_LSB = 4;
  localparam int IOT_LSB = 12;
  localparam int WIN_W = 4;
  localparam logic [4:0] TENURE_RST = 5'h00;
  localparam logic [3:0] IOB_RST = 4'h0;
  localparam logic [3:0] IOT_RST = 4'h0;
  localparam logic [3:0] DECODE32 = 4'h1;
  localparam logic [2:0] TENURE_STEP = 3'h0;
endpackage
`default_nettype wire

// ===== dv/bsl_sec_agent.sv
// Purpose: secondary-bus agent that starts and holds a bridge tenure
// Assumes: go is a level from the bench
// Notes: frame pulse on the first cycle of go
`default_nettype none
module bsl_sec_agent (
  // clock and request
  input wire logic mclk,
  input wire logic go,
  // secondary bus state
  output logic frame_start,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_start = 1'b0;
    busy = 1'b0;
  end
  always @(posedge mclk) begin
    frame_start <= go & !busy;
    busy <= go;
  end
endmodule
`default_nettype wire

// ===== dv/test_bridge_sec_latency_io_window.sv
// Purpose: self-checking bench for the tenure timer and I/O window
// Assumes: one clock, reset held 16 cycles
// Notes: expectations come from bench functions
`default_nettype none
module test_bridge_sec_latency_io_window;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b = 0, rd = 0, wr = 0, req = 0, go = 0, lost = 0, mwi = 0;
  logic [7:0] ad = 0;
  logic [3:0] be = 4'hF, bot = 0, top = 0;
  logic [31:0] wd = 0, ia = 0, rdat;
  logic [15:0] bu = 0, tu = 0;
  logic [4:0] tim = 0;
  logic fs, busy, exp_o, efd, fwd;
  int n_fail = 0, checked = 0, cyc = 0;
  bsl_regs bsl_regs_i(.mclk(mclk), .rst_b(rst_b), .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(ad), .cfg_be_b(be),
    .cfg_wdata(wd), .cfg_rdata(rdat), .io_bottom_upper(bu), .io_top_upper(tu), .sec_frame_start(fs),
    .sec_master_busy(busy), .sec_gnt_lost(lost), .sec_mwi(mwi), .tenure_expired(exp_o),
    .end_after_first_data(efd), .io_req(req), .io_addr(ia), .io_forward(fwd));
  bsl_sec_agent bsl_sec_agent_i(.mclk(mclk), .go(go), .frame_start(fs), .busy(busy));
  ////////////////////////////////////////////////////////////////
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrt(logic [7:0] a, logic [3:0] b, logic [31:0] d);
    @(posedge mclk);
    ad <= a; be <= b; wd <= d; wr <= 1;
    @(posedge mclk);
    wr <= 0;
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    @(posedge mclk);
    ad <= a; rd <= 1;
    @(posedge mclk);
    rd <= 0;
    @(negedge mclk);
    cmp("rdata", e, rdat);
  endtask
  function automatic logic [31:0] iowin();
    return {16'h0, top, 4'h1, bot, 4'h1};
  endfunction
  function automatic logic fexp(logic [15:0] u, logic [15:0] v, logic [31:0] a);
    return {u, bot} <= a[31:12] && a[31:12] <= {v, top};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, a;
    logic [3:0] b;
    logic [15:0] u, v;
    int n;
    void'($urandom(13248));
    repeat (16) @(posedge mclk);
    rst_b <= 1;
    rdc(8'h18, 32'h0);
    rdc(8'h1C, iowin());
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      b = 4'($urandom);
      wrt(8'h18, b, d);
      if (!b[3]) tim = d[31:27];
      rdc(8'h18, {tim, 27'h0});
      wrt(8'h1C, b, d);
      if (!b[0]) bot = d[7:4];
      if (!b[1]) top = d[15:12];
      rdc(8'h1C, iowin());
      wrt(8'h2C, 4'h0, d);
      rdc(8'h2C, 32'h0);
    end
    for (int i = 0; i < 40; i++) begin
      u = 16'($urandom % 2);
      v = u + 16'($urandom % 2);
      a = {16'($urandom % 2), 4'($urandom), 12'($urandom)};
      if (i == 0) a = {u, bot, 12'h0};
      if (i == 1) a = {v, top, 12'hFFF};
      @(posedge mclk);
      bu <= u; tu <= v; ia <= a; req <= 1;
      @(posedge mclk);
      req <= 0;
      @(negedge mclk);
      cmp("io_forward", 32'(fexp(u, v, a)), 32'(fwd));
    end
    for (int s = 1; s < 32; s += 15) begin
      wrt(8'h18, 4'h7, {5'(s), 27'h0});
      @(posedge mclk);
      go <= 1;
      repeat (1) @(posedge mclk);
      n = 0;
      while (n < 300) begin
        @(negedge mclk);
        if (exp_o === 1'b1) break;
        @(posedge mclk);
        n++;
      end
      cmp("tenure", 32'(8 * s), 32'(n));
      @(posedge mclk);
      go <= 0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      cmp("expired_clear", 32'h0, 32'(exp_o));
    end
    wrt(8'h18, 4'h7, 32'h0);
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      mwi <= 1'(m); go <= 1; lost <= 1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      cmp("end_first", 32'(m == 0), 32'(efd));
      cmp("zero_no_expire", 32'h0, 32'(exp_o));
      @(posedge mclk);
      go <= 0; lost <= 0;
      repeat (2) @(posedge mclk);
    end
    final_report();
  end
endmodule
`default_nettype wire
